// ---- gptu_top.sv ----
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - Five 16-bit timers; three in module a, two in module b.
// - Timers run alone or chain within their own module only.
// - Module a timers select timer, gated, counter or incremental mode each.
// - Timer mode in module a divides the clock by 8 up to 1024.
// - Counter mode advances on selected edges of the timer's input pin.
// - Gated mode counts prescaled ticks only while the gate pin is active.
// - Each module a timer has one input pin serving as gate or clock.
// - Incremental mode decodes quadrature input and direction pins into position.
// - Core timer a toggles its latch on every overflow and underflow.
// - Core a latch drives a pin and can clock both aux timers.
// - Aux timers of module a can act as reload or capture for core.
// - Module b timers use pin events or prescaled clock by 4 up to 512.
// - Direction comes from software, optionally inverted by the direction pin level.
// - Core b toggles its latch on wrap; latch clocks aux b or drives pin.
// - Core b wrap is output as a pulse and can reload from capture register.
// - Capture pin edge latches aux b into capture register, optionally clearing it.
// - Capture can also trigger from core a input or direction pin edges.
module gptu_top #(
    parameter int TIMER_W = gptu_pkg::TIMER_W
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  timer_gate_clock_pin,
    input  wire logic [4:0]  timer_direction_pin,
    input  wire logic        capture_trigger_pin,
    output logic             timer_toggle_pin,
    output logic             core_b_toggle_pin,
    output logic             core_b_wrap_pulse,
    output logic             irq
);
    localparam int N  = gptu_pkg::NUM_TIMERS;
    localparam int SW = gptu_pkg::STAT_W;

    logic [gptu_pkg::CTRL_W-1:0]   ctrl_ff [N];
    logic [TIMER_W-1:0]            cnt_ff  [N];
    logic [TIMER_W-1:0]            nxt_cnt [N];
    logic [TIMER_W-1:0]            capture_reload_reg_ff;
    logic [gptu_pkg::CAPCFG_W-1:0] capcfg_ff;
    logic [SW-1:0]                 stat_ff;
    logic [SW-1:0]                 mask_ff;
    logic [SW-1:0]                 stat_set;
    logic [SW-1:0]                 stat_clr;
    logic [gptu_pkg::PRE_W-1:0]    pre_ff;
    logic [gptu_pkg::NUM_PINS-1:0] sync1_ff;
    logic [gptu_pkg::NUM_PINS-1:0] sync2_ff;
    logic [gptu_pkg::NUM_PINS-1:0] prev_ff;
    logic [1:0]                    otl_ff;
    logic [1:0]                    otl_prev_ff;
    logic [N-1:0]                  ev;
    logic [N-1:0]                  up;
    logic [N-1:0]                  wrap;
    logic [N-1:0]                  aux_cap;
    logic                          cap_ev;
    logic                          reload_a;
    logic [TIMER_W-1:0]            reload_a_val;
    logic [31:0]                   prdata_ff;
    logic                          pready_ff;
    logic                          pslverr_ff;
    logic                          irq_ff;
    logic                          tpin_a_ff;
    logic                          tpin_b_ff;
    logic                          wrap_b_ff;
    logic [31:0]                   rd_data;
    logic                          rd_err;
    logic                          setup;
    logic                          done;
    logic                          wr;

    // Edge detection against the selected polarity (bit 0 rising, bit 1 falling)
    function automatic logic edge_hit(input logic cur, input logic prv, input logic [1:0] sel);
        edge_hit = (sel[0] & cur & ~prv) | (sel[1] & ~cur & prv);
    endfunction

    // Prescaler tick when the low n bits of the free counter are all ones
    function automatic logic presc_tick(input logic [9:0] pre, input logic [3:0] n);
        logic [9:0] m;
        m = ~(10'h3FF << n);
        presc_tick = (pre & m) == m;
    endfunction

    // Exact byte address match
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = addr == off;
    endfunction

    assign setup = psel & ~penable;
    assign done  = psel & penable & pready_ff;
    assign wr    = done & pwrite;

    // Pin synchroniser plus one stage for edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 11'h000;
            sync2_ff <= 11'h000;
            prev_ff  <= 11'h000;
        end else begin
            sync1_ff <= {capture_trigger_pin, timer_direction_pin, timer_gate_clock_pin};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Free-running prescaler shared by both modules
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 10'h000;
        end else begin
            pre_ff <= pre_ff + 10'h001;
        end
    end

    // Count event, direction and wrap for every slot
    always_comb begin
        logic [3:0] base;
        logic       in_c;
        logic       in_p;
        logic       dr_c;
        logic       dr_p;
        logic       tick;
        logic       otl_e;
        logic [1:0] esel;
        logic [gptu_pkg::CTRL_W-1:0] c;
        base  = 4'h0;
        in_c  = 1'b0;
        in_p  = 1'b0;
        dr_c  = 1'b0;
        dr_p  = 1'b0;
        tick  = 1'b0;
        otl_e = 1'b0;
        esel  = 2'b00;
        c     = '0;
        ev      = '0;
        up      = '0;
        wrap    = '0;
        aux_cap = '0;
        for (int i = 0; i < N; i++) begin
            c    = ctrl_ff[i];
            in_c = sync2_ff[i];
            in_p = prev_ff[i];
            dr_c = sync2_ff[5+i];
            dr_p = prev_ff[5+i];
            esel = c[gptu_pkg::F_EDGE +: 2];
            base = (i < 3) ? gptu_pkg::A_PRE_BASE : gptu_pkg::B_PRE_BASE;
            tick = presc_tick(pre_ff, {1'b0, c[gptu_pkg::F_PS +: 3]} + base);
            // Aux timers may be clocked by their own module's core latch only
            otl_e = (i < 3) ? edge_hit(otl_ff[0], otl_prev_ff[0], esel)
                            : edge_hit(otl_ff[1], otl_prev_ff[1], esel);
            up[i] = ~(c[gptu_pkg::F_DOWN] ^ (c[gptu_pkg::F_EUD] & dr_c));
            case (gptu_pkg::gptu_mode_t'(c[gptu_pkg::F_MODE +: 2]))
                gptu_pkg::MODE_TIMER: begin
                    ev[i] = tick;
                end
                gptu_pkg::MODE_GATED: begin
                    ev[i] = tick & (in_c == c[gptu_pkg::F_GPOL]);
                end
                gptu_pkg::MODE_COUNTER: begin
                    if (c[gptu_pkg::F_OTLCLK] && i != gptu_pkg::T_CORE_A
                        && i != gptu_pkg::T_CORE_B) begin
                        ev[i] = otl_e;
                    end else begin
                        ev[i] = edge_hit(in_c, in_p, esel);
                    end
                end
                gptu_pkg::MODE_INCR: begin
                    ev[i] = (in_c ^ in_p) | (dr_c ^ dr_p);
                    up[i] = in_c ^ dr_p ^ c[gptu_pkg::F_DOWN];
                end
                default: begin
                    ev[i] = 1'b0;
                end
            endcase
            // Module a aux timers serving the core do not count
            if ((i == gptu_pkg::T_AUX_LOW || i == gptu_pkg::T_AUX_HIGH)
                && c[gptu_pkg::F_AUXFN +: 2] != 2'b00) begin
                ev[i]      = 1'b0;
                aux_cap[i] = (c[gptu_pkg::F_AUXFN +: 2] == gptu_pkg::AUXFN_CAPTURE)
                             & edge_hit(in_c, in_p, esel);
            end
            ev[i]   = ev[i] & c[gptu_pkg::F_RUN];
            wrap[i] = ev[i] & (up[i] ? (&cnt_ff[i]) : (cnt_ff[i] == '0));
        end
    end

    // Reload of core a from an aux timer on core wrap, low aux first
    always_comb begin
        reload_a     = 1'b0;
        reload_a_val = cnt_ff[gptu_pkg::T_AUX_LOW];
        if (ctrl_ff[gptu_pkg::T_AUX_LOW][gptu_pkg::F_AUXFN +: 2] == gptu_pkg::AUXFN_RELOAD) begin
            reload_a = wrap[gptu_pkg::T_CORE_A];
        end else if (ctrl_ff[gptu_pkg::T_AUX_HIGH][gptu_pkg::F_AUXFN +: 2]
                     == gptu_pkg::AUXFN_RELOAD) begin
            reload_a     = wrap[gptu_pkg::T_CORE_A];
            reload_a_val = cnt_ff[gptu_pkg::T_AUX_HIGH];
        end
    end

    // Capture trigger into the capture register
    assign cap_ev = (capcfg_ff[gptu_pkg::F_CAP_PIN]
                     & edge_hit(sync2_ff[10], prev_ff[10], capcfg_ff[gptu_pkg::F_CAP_EDGE +: 2]))
                  | (capcfg_ff[gptu_pkg::F_CAP_AIN]
                     & edge_hit(sync2_ff[1], prev_ff[1], capcfg_ff[gptu_pkg::F_CAP_EDGE +: 2]))
                  | (capcfg_ff[gptu_pkg::F_CAP_ADIR]
                     & edge_hit(sync2_ff[6], prev_ff[6], capcfg_ff[gptu_pkg::F_CAP_EDGE +: 2]));

    // Next count: bus write, then load/clear, then counting
    always_comb begin
        for (int i = 0; i < N; i++) begin
            nxt_cnt[i] = cnt_ff[i];
            if (ev[i]) begin
                nxt_cnt[i] = up[i] ? cnt_ff[i] + 1'b1 : cnt_ff[i] - 1'b1;
            end
            if (aux_cap[i]) begin
                nxt_cnt[i] = cnt_ff[gptu_pkg::T_CORE_A];
            end
            if (i == gptu_pkg::T_CORE_A && reload_a) begin
                nxt_cnt[i] = reload_a_val;
            end
            if (i == gptu_pkg::T_AUX_B && cap_ev && capcfg_ff[gptu_pkg::F_CAP_CLR]) begin
                nxt_cnt[i] = '0;
            end
            if (i == gptu_pkg::T_CORE_B && wrap[i] && ctrl_ff[i][gptu_pkg::F_RELOAD]) begin
                nxt_cnt[i] = capture_reload_reg_ff;
            end
            if (wr && hit(paddr, gptu_pkg::OFF_CNT_BASE + 8'(i) * gptu_pkg::OFF_STEP)) begin
                nxt_cnt[i] = pwdata[TIMER_W-1:0];
            end
        end
    end

    // Timer counts and control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) begin
                cnt_ff[i]  <= gptu_pkg::CNT_RST;
                ctrl_ff[i] <= gptu_pkg::CTRL_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
                if (wr && hit(paddr, gptu_pkg::OFF_CTRL_BASE + 8'(i) * gptu_pkg::OFF_STEP)) begin
                    ctrl_ff[i] <= pwdata[gptu_pkg::CTRL_W-1:0];
                end
            end
        end
    end

    // Capture register and its configuration; capture wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_reload_reg_ff <= gptu_pkg::CNT_RST;
            capcfg_ff             <= gptu_pkg::CAPCFG_RST;
        end else begin
            if (cap_ev) begin
                capture_reload_reg_ff <= cnt_ff[gptu_pkg::T_AUX_B];
            end else if (wr && hit(paddr, gptu_pkg::OFF_CAPTURE)) begin
                capture_reload_reg_ff <= pwdata[TIMER_W-1:0];
            end
            if (wr && hit(paddr, gptu_pkg::OFF_CAPCFG)) begin
                capcfg_ff <= pwdata[gptu_pkg::CAPCFG_W-1:0];
            end
        end
    end

    // Toggle latches and pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            otl_ff      <= 2'b00;
            otl_prev_ff <= 2'b00;
            tpin_a_ff   <= 1'b0;
            tpin_b_ff   <= 1'b0;
            wrap_b_ff   <= 1'b0;
        end else begin
            otl_ff[0]   <= otl_ff[0] ^ wrap[gptu_pkg::T_CORE_A];
            otl_ff[1]   <= otl_ff[1] ^ wrap[gptu_pkg::T_CORE_B];
            otl_prev_ff <= otl_ff;
            tpin_a_ff   <= otl_ff[0] & ctrl_ff[gptu_pkg::T_CORE_A][gptu_pkg::F_OUTEN];
            tpin_b_ff   <= otl_ff[1] & ctrl_ff[gptu_pkg::T_CORE_B][gptu_pkg::F_OUTEN];
            wrap_b_ff   <= wrap[gptu_pkg::T_CORE_B];
        end
    end

    // Sticky status, cleared by reading only the bits the read returned
    assign stat_set = {|aux_cap, cap_ev, wrap};
    assign stat_clr = (done && !pwrite && hit(paddr, gptu_pkg::OFF_STATUS))
                      ? prdata_ff[SW-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= gptu_pkg::STAT_RST;
            mask_ff <= gptu_pkg::STAT_RST;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~stat_clr) | stat_set;
            if (wr && hit(paddr, gptu_pkg::OFF_MASK)) begin
                mask_ff <= pwdata[SW-1:0];
            end
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    // Read mux; unmapped addresses answer with an error
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b1;
        for (int i = 0; i < N; i++) begin
            if (hit(paddr, gptu_pkg::OFF_CTRL_BASE + 8'(i) * gptu_pkg::OFF_STEP)) begin
                rd_data = {16'h0000, ctrl_ff[i]};
                rd_err  = 1'b0;
            end
            if (hit(paddr, gptu_pkg::OFF_CNT_BASE + 8'(i) * gptu_pkg::OFF_STEP)) begin
                rd_data = 32'(cnt_ff[i]);
                rd_err  = 1'b0;
            end
        end
        if (hit(paddr, gptu_pkg::OFF_CAPTURE)) begin
            rd_data = 32'(capture_reload_reg_ff);
            rd_err  = 1'b0;
        end
        if (hit(paddr, gptu_pkg::OFF_STATUS)) begin
            rd_data = {25'h0000000, stat_ff};
            rd_err  = 1'b0;
        end
        if (hit(paddr, gptu_pkg::OFF_MASK)) begin
            rd_data = {25'h0000000, mask_ff};
            rd_err  = 1'b0;
        end
        if (hit(paddr, gptu_pkg::OFF_CAPCFG)) begin
            rd_data = {26'h0000000, capcfg_ff};
            rd_err  = 1'b0;
        end
    end

    // APB answer: no wait state, data and error taken at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr_ff <= rd_err;
            end else if (done) begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign irq               = irq_ff;
    assign timer_toggle_pin  = tpin_a_ff;
    assign core_b_toggle_pin = tpin_b_ff;
    assign core_b_wrap_pulse = wrap_b_ff;

    a_wrap_up_zero: assert property (@(posedge pclk) disable iff (!presetn)
        wrap[4] && up[4] && !ctrl_ff[4][gptu_pkg::F_RELOAD] && !wr
        |=> cnt_ff[4] == '0 && stat_ff[4])
        else $error("core b up wrap did not reach zero");
    a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
        wrap[1] |=> otl_ff[0] != $past(otl_ff[0]) ##1 otl_prev_ff[0] == $past(otl_ff[0]))
        else $error("core a latch did not toggle on wrap");
    a_capture_value: assert property (@(posedge pclk) disable iff (!presetn)
        cap_ev |=> capture_reload_reg_ff == $past(cnt_ff[3]))
        else $error("capture register missed aux b value");
    a_clear_after: assert property (@(posedge pclk) disable iff (!presetn)
        cap_ev && capcfg_ff[gptu_pkg::F_CAP_CLR] && !wr |=> cnt_ff[3] == '0)
        else $error("aux b not cleared after capture");
    a_reload_core_b: assert property (@(posedge pclk) disable iff (!presetn)
        wrap[4] && ctrl_ff[4][gptu_pkg::F_RELOAD] && !wr
        |=> cnt_ff[4] == $past(capture_reload_reg_ff) && core_b_wrap_pulse)
        else $error("core b reload or wrap pulse wrong");
    a_presc_rate: assert property (@(posedge pclk) disable iff (!presetn)
        ev[1] && ctrl_ff[1][gptu_pkg::F_MODE +: 2] == 2'b00 && ctrl_ff[1][2:0] == 3'h0
        |-> pre_ff[2:0] == 3'h7 ##1 !ev[1] [*7])
        else $error("module a divide by 8 violated");
    a_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff[0][gptu_pkg::F_MODE +: 2] == 2'b01
        && sync2_ff[0] != ctrl_ff[0][gptu_pkg::F_GPOL] |-> !ev[0])
        else $error("gated timer counted with gate inactive");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (stat_ff & mask_ff) != '0 |=> irq)
        else $error("interrupt not raised for unmasked status");
    a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(capture_trigger_pin) ##1 capture_trigger_pin |=> sync2_ff[10])
        else $error("capture pin not seen after two stages");
    a_pready_once: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("apb ready timing wrong");
endmodule

// ---- gptu_pkg.sv ----
package gptu_pkg;
    // Structure
    localparam int NUM_TIMERS = 5;
    localparam int TIMER_W    = 16;
    localparam int PRE_W      = 10;
    localparam int NUM_PINS   = 11;
    localparam int STAT_W     = 7;

    // Timer slots: module a is slots 0..2, module b is slots 3..4
    localparam int T_AUX_LOW  = 0;
    localparam int T_CORE_A   = 1;
    localparam int T_AUX_HIGH = 2;
    localparam int T_AUX_B    = 3;
    localparam int T_CORE_B   = 4;

    // Prescaler: shift for code 000b (divide by 8 in module a, by 4 in module b)
    localparam logic [3:0] A_PRE_BASE = 4'h3;
    localparam logic [3:0] B_PRE_BASE = 4'h2;

    // Register byte offsets; control and count registers step by one word
    localparam logic [7:0] OFF_CTRL_BASE = 8'h00;
    localparam logic [7:0] OFF_CNT_BASE  = 8'h14;
    localparam logic [7:0] OFF_CAPTURE   = 8'h28;
    localparam logic [7:0] OFF_STATUS    = 8'h2C;
    localparam logic [7:0] OFF_MASK      = 8'h30;
    localparam logic [7:0] OFF_CAPCFG    = 8'h34;
    localparam logic [7:0] OFF_STEP      = 8'h04;

    // Timer control fields
    localparam int CTRL_W   = 16;
    localparam int F_PS     = 0;
    localparam int F_MODE   = 3;
    localparam int F_RUN    = 5;
    localparam int F_DOWN   = 6;
    localparam int F_EUD    = 7;
    localparam int F_GPOL   = 8;
    localparam int F_EDGE   = 9;
    localparam int F_OTLCLK = 11;
    localparam int F_AUXFN  = 12;
    localparam int F_OUTEN  = 14;
    localparam int F_RELOAD = 15;

    // Capture configuration fields
    localparam int CAPCFG_W   = 6;
    localparam int F_CAP_PIN  = 0;
    localparam int F_CAP_AIN  = 1;
    localparam int F_CAP_ADIR = 2;
    localparam int F_CAP_EDGE = 3;
    localparam int F_CAP_CLR  = 5;

    // Status bits 0..4 are over/underflow of each slot
    localparam int S_CAP    = 5;
    localparam int S_AUXCAP = 6;

    // Values after reset
    localparam logic [CTRL_W-1:0]   CTRL_RST   = 16'h0000;
    localparam logic [TIMER_W-1:0]  CNT_RST    = 16'h0000;
    localparam logic [STAT_W-1:0]   STAT_RST   = 7'h00;
    localparam logic [CAPCFG_W-1:0] CAPCFG_RST = 6'h00;

    // Auxiliary timer functions
    localparam logic [1:0] AUXFN_RELOAD  = 2'h1;
    localparam logic [1:0] AUXFN_CAPTURE = 2'h2;

    typedef enum logic [1:0] {
        MODE_TIMER   = 2'b00,
        MODE_GATED   = 2'b01,
        MODE_COUNTER = 2'b10,
        MODE_INCR    = 2'b11
    } gptu_mode_t;
endpackage

// ---- gptu_pin_model.sv ----
`timescale 1ns/1ns
// Far side pins: gate/count, direction and capture signals
module gptu_pin_model (
    input  wire logic       pclk,
    output logic      [4:0] gate,
    output logic      [4:0] dir,
    output logic            cap
);
    // Idle levels at time zero
    initial begin
        gate = 5'h00;
        dir  = 5'h00;
        cap  = 1'b0;
    end
    // One full pulse; each level held past the synchronisers
    task automatic pulse(input int idx);
        repeat (2) begin
            @(posedge pclk);
            if (idx == 5) cap <= ~cap;
            else gate[idx] <= ~gate[idx];
            repeat (4) @(posedge pclk);
        end
    endtask
endmodule

// ---- general_purpose_timer_unit_tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module general_purpose_timer_unit_tb;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, tog_a, tog_b, wrap_b, irq;
    logic [4:0]  gate, dir;
    logic        cap;
    int          bad_count, compares;
    int          wb_cnt = 0;
    localparam logic [31:0] RUN = 32'h1 << gptu_pkg::F_RUN;
    localparam logic [31:0] CUP = (32'h2 << gptu_pkg::F_MODE) | RUN
        | (32'h1 << gptu_pkg::F_EDGE) | (32'h1 << gptu_pkg::F_OUTEN);

    gptu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_gate_clock_pin(gate),
        .timer_direction_pin(dir), .capture_trigger_pin(cap),
        .timer_toggle_pin(tog_a), .core_b_toggle_pin(tog_b),
        .core_b_wrap_pulse(wrap_b), .irq(irq));
    gptu_pin_model pins (.pclk(pclk), .gate(gate), .dir(dir), .cap(cap));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Count core b wrap pulses while they stand
    always @(posedge pclk) begin
        if (wrap_b === 1'b1) wb_cnt <= wb_cnt + 1;
    end
    // Register addresses per slot
    function automatic logic [7:0] ca(int s);
        return gptu_pkg::OFF_CTRL_BASE + 8'(s * 4);
    endfunction
    function automatic logic [7:0] na(int s);
        return gptu_pkg::OFF_CNT_BASE + 8'(s * 4);
    endfunction
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    // Count read with a tolerance for prescaler phase
    task automatic rng(input string nm, input logic [7:0] a, input int e, input int t);
        apb(1'b0, a, 32'h0);
        `CHK(nm, 1'b1, (rd[15:0] >= e - t && rd[15:0] <= e + t))
    endtask
    task automatic complete_run();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        int sh;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; bad_count = 0; compares = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rc("ctrl1", ca(1), 32'h0);
        rc("cnt1", na(1), 32'h0);
        rc("status", gptu_pkg::OFF_STATUS, 32'h0);
        apb(1'b0, 8'h38, 32'h0);
        `CHK("unmapped", 1'b1, err)
        $display("test reset done");
        wr(gptu_pkg::OFF_MASK, 32'h2);
        wr(ca(1), CUP);
        repeat (3) pins.pulse(1);
        rc("count up", na(1), 32'h3);
        wr(na(1), 32'hFFFF);
        pins.pulse(1);
        rc("overflow", na(1), 32'h0);
        `CHK("toggle a", 1'b1, tog_a)
        `CHK("irq set", 1'b1, irq)
        rc("status", gptu_pkg::OFF_STATUS, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK("irq clr", 1'b0, irq)
        wr(ca(1), CUP | (32'h1 << gptu_pkg::F_EUD));
        pins.dir[1] <= 1'b1;
        pins.pulse(1);
        rc("underflow", na(1), 32'hFFFF);
        `CHK("toggle a", 1'b0, tog_a)
        $display("test counter done");
        wr(na(3), 32'h1234);
        wr(gptu_pkg::OFF_CAPCFG, 32'h29);
        pins.pulse(5);
        rc("capture", gptu_pkg::OFF_CAPTURE, 32'h1234);
        rc("aux clear", na(3), 32'h0);
        wr(na(3), 32'h55AA);
        wr(gptu_pkg::OFF_CAPCFG, 32'h0A);
        pins.pulse(1);
        rc("cap core in", gptu_pkg::OFF_CAPTURE, 32'h55AA);
        wr(na(3), 32'h0077);
        wr(gptu_pkg::OFF_CAPCFG, 32'h14);
        pins.dir[1] <= 1'b0;
        repeat (5) @(posedge pclk);
        rc("cap core dir", gptu_pkg::OFF_CAPTURE, 32'h0077);
        $display("test capture done");
        for (int k = 0; k < 4; k++) begin
            sh = (k % 2 == 0) ? gptu_pkg::A_PRE_BASE : gptu_pkg::B_PRE_BASE;
            sh = sh + ((k < 2) ? 0 : 7);
            wr(na(k % 2 == 0 ? 1 : 4), 32'h0);
            wr(ca(k % 2 == 0 ? 1 : 4), RUN | ((k < 2) ? 32'h0 : 32'h7));
            repeat (2046) @(posedge pclk);
            wr(ca(k % 2 == 0 ? 1 : 4), 32'h0);
            rng("prescale", na(k % 2 == 0 ? 1 : 4), 2048 >> sh, 1);
        end
        $display("test prescale done");
        wr(ca(0), RUN | (32'h1 << gptu_pkg::F_MODE) | (32'h1 << gptu_pkg::F_GPOL));
        repeat (80) @(posedge pclk);
        rc("gate closed", na(0), 32'h0);
        pins.gate[0] <= 1'b1;
        repeat (158) @(posedge pclk);
        wr(ca(0), 32'h0);
        rng("gate open", na(0), 160 >> gptu_pkg::A_PRE_BASE, 2);
        $display("test gated done");
        wr(na(0), 32'h100);
        wr(ca(0), 32'h1 << gptu_pkg::F_AUXFN);
        wr(na(1), 32'hFFFF);
        wr(ca(1), CUP);
        pins.pulse(1);
        rc("reload a", na(1), 32'h100);
        wr(ca(2), RUN | (32'h3 << gptu_pkg::F_MODE));
        pins.gate[2] <= 1'b1;
        repeat (4) @(posedge pclk);
        pins.dir[2] <= 1'b1;
        repeat (4) @(posedge pclk);
        rc("incr up", na(2), 32'h2);
        $display("test module a done");
        wr(gptu_pkg::OFF_CAPTURE, 32'hFFFE);
        wr(na(3), 32'h0);
        wr(ca(3), RUN | (32'h2 << gptu_pkg::F_MODE) | (32'h3 << gptu_pkg::F_EDGE)
            | (32'h1 << gptu_pkg::F_OTLCLK));
        for (int k = 0; k < 2; k++) begin
            wr(na(4), 32'hFFFF);
            wr(ca(4), CUP | (32'(k) << gptu_pkg::F_RELOAD));
            pins.pulse(4);
            rc("core b", na(4), k ? 32'hFFFE : 32'h0);
            `CHK("toggle b", 1'(1 - k), tog_b)
        end
        rc("aux b chain", na(3), 32'h2);
        `CHK("wrap pulses", 2, wb_cnt)
        $display("test module b done");
        complete_run();
    end
endmodule
